// ==== rtl/sbs_pkg.sv ====
`default_nettype none

package sbs_pkg;

  // ---------------------------------------------------------------------
  // Status byte layout.
  // ---------------------------------------------------------------------
  localparam int unsigned SB_ERR_BIT = 2;   // Error/event queue not empty.
  localparam int unsigned SB_OUT_BIT = 4;   // Output buffer holds a reply.
  localparam int unsigned SB_ESB_BIT = 5;   // Masked standard event summary.
  localparam int unsigned SB_RQS_BIT = 6;   // Request service summary.

  // Service request mask: bits that enable a request, and read-back mask.
  localparam logic [7:0] MASK_USED  = 8'h34;
  localparam logic [7:0] MASK_RDBK  = 8'hbf;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] STAT_RST   = 8'h00;
  localparam logic [7:0] STAT_UNUSED = 8'h8b;

  // Interrupt level select switch width and the number of bus levels.
  localparam int unsigned LVL_W      = 3;
  localparam int unsigned IRQ_LINES  = 7;
  localparam logic [2:0]  LVL_RST    = 3'h0;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------------
  // Carriers.
  // ---------------------------------------------------------------------
  // Summary conditions from the neighbouring status logic.
  typedef struct packed {
    logic       err_not_empty;
    logic       out_not_empty;
    logic [7:0] std_event;
    logic [7:0] std_enable;
  } sbs_src_t;

  // Decoded word-serial status commands, each a one-cycle strobe.
  typedef struct packed {
    logic       mask_wr;
    logic [7:0] mask_data;
    logic       mask_rd;
    logic       stb_query;
    logic       read_stb;
  } sbs_cmd_t;

  // Kind of answer held on the reply port.
  typedef enum logic [1:0] {
    SBS_ANS_NONE,
    SBS_ANS_MASK,
    SBS_ANS_QUERY,
    SBS_ANS_READ_STB
  } sbs_ans_t;

  // Complete state of the status block.
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] stat;
    logic       summ;
    logic       rqs;
    logic [7:0] resp_data;
    sbs_ans_t   resp_kind;
    logic       resp_valid;
    logic [2:0] lvl;
  } sbs_state_t;

  localparam sbs_state_t ST_RST = '{
    mask:       MASK_RST,
    stat:       STAT_RST,
    summ:       1'b0,
    rqs:        1'b0,
    resp_data:  8'h00,
    resp_kind:  SBS_ANS_NONE,
    resp_valid: 1'b0,
    lvl:        LVL_RST
  };

endpackage : sbs_pkg

`default_nettype wire

// ==== rtl/sbs_status_byte.sv ====
// Contract
// - Mask AND status byte non-zero raises the Request True interrupt.
// - Only mask bits 2, 4 and 5 can enable a request.
// - Mask read-back returns 0 to 63 or 128 to 191, with bit 6 always zero.
// - Status byte query returns the byte with bits 0, 1, 3 and 7 always zero.
// - Read STB also returns the status byte; bit 6 is destructive there.
// - Bit 2 is one exactly while the error queue is not empty.
// - Bit 4 is one while the output buffer holds a response.
// - Bit 5 is one while standard events AND their enables are non-zero.
// - Bit 6 is set when other status bits AND the mask are non-zero.
// - On bit 6 becoming set, interrupt on the switch-selected level.
// - First Read STB after setting shows bit 6 one, later ones zero.
// - Status query never clears bit 6; it follows the masked summary.

`default_nettype none

module sbs_status_byte (
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire sbs_pkg::sbs_src_t              src_in,
  input  wire sbs_pkg::sbs_cmd_t              cmd_in,
  input  wire logic [sbs_pkg::LVL_W-1:0]      lvl_sel_in,
  output logic                                resp_valid_out,
  output sbs_pkg::sbs_ans_t                   resp_kind_out,
  output logic [7:0]                          resp_data_out,
  output logic [7:0]                          mask_out,
  output logic                                req_true_out,
  output logic [sbs_pkg::IRQ_LINES-1:0]       irq_oe_out,
  output logic [sbs_pkg::IRQ_LINES-1:0]       irq_o_out
);

  // ---------------------------------------------------------------------
  // State and the synchronised level switch.
  // ---------------------------------------------------------------------
  sbs_pkg::sbs_state_t         st_q;
  sbs_pkg::sbs_state_t         st_d;
  logic [sbs_pkg::LVL_W-1:0]   lvl_sync;

  // The switch is a pin on another timing base, so it passes two stages.
  sbs_sync #(
    .WIDTH (sbs_pkg::LVL_W)
  ) u_lvl_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (lvl_sel_in),
    .sync_out (lvl_sync)
  );

  // ---------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------
  // The status byte is rebuilt every cycle from the live conditions, so
  // bits 2, 4 and 5 are levels and never latch a past event. The summary
  // is computed from the new byte and the new mask, so a mask write and a
  // status change take effect on the same edge. The request flag is set
  // on the rising summary and cleared only by Read STB; if both happen in
  // one cycle the set wins, so a fresh request is never swallowed.
  always_comb begin
    logic [7:0] stat_v;
    logic       rise_v;
    stat_v = sbs_pkg::STAT_RST;
    rise_v = 1'b0;
    st_d   = st_q;

    // Mask write keeps every bit except bit 6, which is never stored.
    if (cmd_in.mask_wr) begin
      st_d.mask = cmd_in.mask_data & sbs_pkg::MASK_RDBK;
    end

    // Status byte contents.
    stat_v[sbs_pkg::SB_ERR_BIT] = src_in.err_not_empty;
    stat_v[sbs_pkg::SB_OUT_BIT] = src_in.out_not_empty;
    stat_v[sbs_pkg::SB_ESB_BIT] =
      |(src_in.std_event & src_in.std_enable);
    st_d.stat = stat_v & ~sbs_pkg::STAT_UNUSED;

    // Summary: only the enabling mask bits take part.
    st_d.summ = |(st_d.stat & st_d.mask & sbs_pkg::MASK_USED);
    rise_v    = st_d.summ && !st_q.summ;

    // Request flag: destructive on Read STB, set wins over clear.
    if (cmd_in.read_stb) begin
      st_d.rqs = 1'b0;
    end
    if (rise_v) begin
      st_d.rqs = 1'b1;
    end

    // Level switch is followed continuously.
    st_d.lvl = lvl_sync;

    // Answers: one per cycle; Read STB, then the query, then read-back.
    st_d.resp_valid = 1'b0;
    st_d.resp_kind  = sbs_pkg::SBS_ANS_NONE;
    if (cmd_in.read_stb) begin
      st_d.resp_valid = 1'b1;
      st_d.resp_kind  = sbs_pkg::SBS_ANS_READ_STB;
      st_d.resp_data  = st_q.stat;
      st_d.resp_data[sbs_pkg::SB_RQS_BIT] = st_q.rqs;
    end else if (cmd_in.stb_query) begin
      st_d.resp_valid = 1'b1;
      st_d.resp_kind  = sbs_pkg::SBS_ANS_QUERY;
      st_d.resp_data  = st_q.stat;
      st_d.resp_data[sbs_pkg::SB_RQS_BIT] = st_q.summ;
    end else if (cmd_in.mask_rd) begin
      st_d.resp_valid = 1'b1;
      st_d.resp_kind  = sbs_pkg::SBS_ANS_MASK;
      st_d.resp_data  = st_q.mask & sbs_pkg::MASK_RDBK;
    end
  end

  // ---------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------
  // Reset loads constants only; the switch is picked up after release.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= sbs_pkg::ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------
  // Reply and mask come straight from flip-flops.
  assign resp_valid_out = st_q.resp_valid;
  assign resp_kind_out  = st_q.resp_kind;
  assign resp_data_out  = st_q.resp_data;
  assign mask_out       = st_q.mask;
  assign req_true_out   = st_q.rqs;

  // The interrupt lines are open drain and active low: the data is always
  // zero and the enable pulls the chosen level. Level 0 on the switch
  // selects no line, which leaves the request visible only on
  // req_true_out; that keeps a wrongly set switch from hitting the bus.
  always_comb begin
    irq_oe_out = '0;
    irq_o_out  = '0;
    for (int i = 0; i < sbs_pkg::IRQ_LINES; i++) begin
      if (st_q.rqs && (st_q.lvl == 3'(i + 1))) begin
        irq_oe_out[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic chk_past_ok_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_past_ok_q <= 1'b0;
    end else begin
      chk_past_ok_q <= 1'b1;
    end
  end

  chk_summary_irq: assert property (
    chk_past_ok_q && $rose(st_q.summ) |-> req_true_out
  ) else $error("Summary rose without a request.");

  chk_unused_mask: assert property (
    cmd_in.mask_wr && ((cmd_in.mask_data & sbs_pkg::MASK_USED) == 8'h00)
    |=> !st_q.summ
  ) else $error("Unused mask bits raised the summary.");

  chk_mask_rdbk: assert property (
    cmd_in.mask_rd && !cmd_in.read_stb && !cmd_in.stb_query
    |=> resp_valid_out && (resp_kind_out == sbs_pkg::SBS_ANS_MASK)
        && (resp_data_out == ($past(st_q.mask) & 8'hbf))
  ) else $error("Mask read-back is wrong.");

  chk_query_answer: assert property (
    cmd_in.stb_query && !cmd_in.read_stb
    |=> resp_valid_out && (resp_kind_out == sbs_pkg::SBS_ANS_QUERY)
        && (resp_data_out[5:0] == $past(st_q.stat[5:0]))
  ) else $error("Status query answer is wrong.");

  chk_read_stb_once: assert property (
    cmd_in.read_stb
    |=> (resp_data_out[6] == $past(st_q.rqs))
        && (!st_q.rqs || $rose(st_q.summ))
  ) else $error("Read STB bit 6 not destructive.");

  chk_clear_cause: assert property (
    chk_past_ok_q && $fell(st_q.rqs) |-> $past(cmd_in.read_stb)
  ) else $error("Request flag cleared without Read STB.");

  chk_query_hold: assert property (
    cmd_in.stb_query && !cmd_in.read_stb && st_q.summ
    |=> resp_data_out[6] ##0 $stable(st_q.rqs)
  ) else $error("Status query lost or cleared bit 6.");

  chk_err_bit: assert property (
    src_in.err_not_empty |=> st_q.stat[2]
  ) else $error("Error queue bit does not follow.");

  chk_out_bit: assert property (
    src_in.out_not_empty |=> st_q.stat[4]
  ) else $error("Output buffer bit does not follow.");

  chk_esb_bit: assert property (
    (|(src_in.std_event & src_in.std_enable)) |=> st_q.stat[5]
  ) else $error("Event summary bit does not follow.");

  chk_summary_cause: assert property (
    st_q.summ |-> (|(st_q.stat & st_q.mask & 8'h34))
  ) else $error("Summary set with no enabled cause.");

  chk_irq_level: assert property (
    req_true_out && (st_q.lvl == 3'h3) |-> irq_oe_out == 7'h04
  ) else $error("Interrupt on the wrong level.");

  chk_unused_zero: assert property (
    (st_q.stat & 8'h8b) == 8'h00
  ) else $error("Unused status bits are not zero.");

  // Reply port: every answer is a one-cycle pulse of the right kind, and
  // nothing answers unless a read was taken on the edge before.
  chk_answer_pulse: assert property (
    !(cmd_in.mask_rd || cmd_in.stb_query || cmd_in.read_stb)
    |=> !resp_valid_out && (resp_kind_out == sbs_pkg::SBS_ANS_NONE)
  ) else $error("Answer valid without a read command.");

  chk_read_stb_data: assert property (
    cmd_in.read_stb
    |=> resp_valid_out && (resp_kind_out == sbs_pkg::SBS_ANS_READ_STB)
        && (resp_data_out[5:0] == $past(st_q.stat[5:0]))
        && !resp_data_out[7]
  ) else $error("Read STB answer is wrong.");

  chk_query_bit6: assert property (
    cmd_in.stb_query && !cmd_in.read_stb
    |=> resp_data_out[6] == $past(st_q.summ)
  ) else $error("Status query bit 6 does not follow the summary.");

  chk_query_unused: assert property (
    cmd_in.stb_query && !cmd_in.read_stb
    |=> (resp_data_out & 8'h8b) == 8'h00
  ) else $error("Status query shows an unused bit.");

  // Mask storage: bit 6 is dropped on the way in, so it can never read
  // back as one, whatever the commander wrote.
  chk_mask_write: assert property (
    cmd_in.mask_wr |=> mask_out == ($past(cmd_in.mask_data) & 8'hbf)
  ) else $error("Mask write not stored.");

  chk_mask_bit6: assert property (
    !mask_out[6]
  ) else $error("Mask bit 6 was stored.");

  chk_rdbk_unused: assert property (
    cmd_in.mask_rd && !cmd_in.read_stb && !cmd_in.stb_query
    |=> !resp_data_out[6]
  ) else $error("Mask read-back shows bit 6.");

  // Status levels must also fall when their condition goes away, or a
  // drained queue would keep raising requests.
  chk_err_clear: assert property (
    !src_in.err_not_empty |=> !st_q.stat[2]
  ) else $error("Error queue bit stuck at one.");

  chk_out_clear: assert property (
    !src_in.out_not_empty |=> !st_q.stat[4]
  ) else $error("Output buffer bit stuck at one.");

  chk_esb_clear: assert property (
    !(|(src_in.std_event & src_in.std_enable)) |=> !st_q.stat[5]
  ) else $error("Event summary bit stuck at one.");

  chk_summary_set: assert property (
    (|(st_q.stat & st_q.mask & 8'h34)) |-> st_q.summ
  ) else $error("Enabled cause without a summary.");

  // Interrupt lines: open drain, one line at most, only while a request
  // is pending, and on the level that the synchronised switch shows.
  chk_rqs_source: assert property (
    chk_past_ok_q && $rose(st_q.rqs) |-> $rose(st_q.summ)
  ) else $error("Request flag set without a rising summary.");

  chk_irq_quiet: assert property (
    !req_true_out |-> (irq_oe_out == 7'h00)
  ) else $error("Interrupt line driven with no request.");

  chk_irq_single: assert property (
    $onehot0(irq_oe_out) && (irq_o_out == 7'h00)
  ) else $error("Interrupt lines driven wrongly.");

  chk_lvl_follow: assert property (
    chk_past_ok_q |-> st_q.lvl == $past(lvl_sync)
  ) else $error("Interrupt level does not follow the switch.");

endmodule // sbs_status_byte

`default_nettype wire

// ==== rtl/sbs_sync.sv ====
`default_nettype none

// Two-stage synchroniser for a level coming from a pin.
module sbs_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------------
  // Stages.
  // ---------------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second, so no logic sees a metastable
  // value.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sbs_sync

`default_nettype wire

// ==== verification/sbs_cmdr.sv ====
`default_nettype none

// ---------------------------------------------------------------------
// Commander model issuing word-serial status commands.
// ---------------------------------------------------------------------
module sbs_cmdr (
  input  wire logic                  clk_in,
  input  wire logic                  resp_valid_in,
  input  wire sbs_pkg::sbs_ans_t     resp_kind_in,
  input  wire logic [7:0]            resp_data_in,
  output var  sbs_pkg::sbs_cmd_t     cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet command port from time zero.
  initial cmd_out = '0;

  // Op 0 writes the mask, 1 reads it back, 2 queries, 3 is Read STB.
  // Idle data shows the inverse byte, so a stale value never matches.
  task automatic send(input logic [1:0] op, input logic [7:0] d,
                      input int gap, output logic [7:0] r,
                      output sbs_pkg::sbs_ans_t k);
    sbs_pkg::sbs_cmd_t c;
    sbs_pkg::sbs_cmd_t idle;
    int n;
    c = '0;
    idle = '0;
    c.mask_data = d;
    idle.mask_data = ~d;
    c.mask_wr = (op == 2'h0);
    c.mask_rd = (op == 2'h1);
    c.stb_query = (op == 2'h2);
    c.read_stb = (op == 2'h3);
    r = 8'h00;
    k = sbs_pkg::SBS_ANS_NONE;
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    cmd_out <= c;
    @(posedge clk_in);
    cmd_out <= idle;
    if (op != 2'h0) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (resp_valid_in !== 1'b1 && n < 4);
      // The answer is due one edge after the taking edge; a late one is
      // reported as no answer, so the caller's kind check trips on it.
      r = resp_data_in;
      k = (n == 1) ? resp_kind_in : sbs_pkg::SBS_ANS_NONE;
    end
  endtask
endmodule // sbs_cmdr

`default_nettype wire

// ==== verification/test_status_byte_service_request.sv ====
`default_nettype none

// ---------------------------------------------------------------------
// Self-checking bench of the status byte block.
// ---------------------------------------------------------------------
module test_status_byte_service_request;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  sbs_pkg::sbs_src_t src = '0;
  sbs_pkg::sbs_src_t ns;
  sbs_pkg::sbs_cmd_t cmd;
  sbs_pkg::sbs_ans_t rk, k;
  logic [2:0]        lvl = 3'h0;
  logic [2:0]        lv;
  logic [7:0]        rd, mo, r, m, st, q;
  logic              rv, rt, sm;
  logic [6:0]        oe, oo;
  int                mismatches = 0;
  int                tests_run = 0;
  int                seed = 10610;
  int                gap;

  initial forever #2 clk_in = ~clk_in;

  sbs_status_byte dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .src_in(src), .cmd_in(cmd), .lvl_sel_in(lvl),
    .resp_valid_out(rv), .resp_kind_out(rk), .resp_data_out(rd),
    .mask_out(mo), .req_true_out(rt), .irq_oe_out(oe), .irq_o_out(oo));

  sbs_cmdr cmdr (.clk_in(clk_in), .resp_valid_in(rv),
    .resp_kind_in(rk), .resp_data_in(rd), .cmd_out(cmd));

  // Expected status byte from the source conditions.
  function automatic logic [7:0] stat_of(sbs_pkg::sbs_src_t s);
    return {2'b00, |(s.std_event & s.std_enable), s.out_not_empty,
            1'b0, s.err_not_empty, 2'b00};
  endfunction

  // Only the used mask bits may form the summary.
  function automatic logic summ_of(logic [7:0] s, logic [7:0] msk);
    return |(s & msk & sbs_pkg::MASK_USED);
  endfunction

  // Switch level 0 drives no line; level n drives line n.
  function automatic logic [6:0] irq_of(logic [2:0] l, logic on);
    return (on && l != 3'h0) ? (7'h01 << (l - 3'h1)) : 7'h00;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Each round clears the pending flag, then applies new sources, a new mask and a new switch level.
  initial begin
    repeat (20) @(posedge clk_in);
    #1 chk(mo, 8'h00);
    chk({7'h00, rt}, 8'h00);
    chk({1'b0, oe}, 8'h00);
    @(posedge clk_in) rst_n_in <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      cmdr.send(2'h0, 8'h00, 0, r, k);
      @(posedge clk_in) src <= '0;
      repeat (3) @(posedge clk_in);
      cmdr.send(2'h3, 8'h00, 0, r, k);
      ns = 18'($random(seed));
      m = 8'($random(seed));
      lv = 3'($random(seed));
      gap = $random(seed) & 3;
      if (i == 0) begin
        ns = '1;
        m = 8'hff;
        lv = 3'h3; // Exercises the level-three line check.
      end
      if (i == 1) begin
        ns = '1;
        m = 8'hcb; // Only unused mask bits: never a request.
      end
      if (i == 2) begin
        ns = '1;
        m = 8'h04; // Request with the switch at 0: no line driven.
        lv = 3'h0;
      end
      @(posedge clk_in) begin
        src <= ns;
        lvl <= lv;
      end
      cmdr.send(2'h0, m, gap, r, k);
      repeat (4) @(posedge clk_in);
      st = stat_of(ns);
      sm = summ_of(st, m);
      q = {1'b0, sm, st[5:0]};
      #1 chk(mo, m & 8'hbf);
      chk({7'h00, rt}, {7'h00, sm});
      chk({1'b0, oe}, {1'b0, irq_of(lv, sm)});
      chk({1'b0, oo}, 8'h00);
      cmdr.send(2'h1, 8'h00, gap, r, k);
      chk(r, m & 8'hbf);
      chk({6'h00, k}, {6'h00, sbs_pkg::SBS_ANS_MASK});
      cmdr.send(2'h2, 8'h00, 0, r, k);
      chk(r, q);
      chk({6'h00, k}, {6'h00, sbs_pkg::SBS_ANS_QUERY});
      cmdr.send(2'h3, 8'h00, gap, r, k);
      chk(r, q);
      chk({6'h00, k}, {6'h00, sbs_pkg::SBS_ANS_READ_STB});
      cmdr.send(2'h3, 8'h00, 0, r, k);
      chk(r, {2'b00, st[5:0]});
      chk({6'h00, k}, {6'h00, sbs_pkg::SBS_ANS_READ_STB});
      cmdr.send(2'h2, 8'h00, 0, r, k);
      chk(r, q);
      chk({6'h00, k}, {6'h00, sbs_pkg::SBS_ANS_QUERY});
      #1 chk({7'h00, rt}, 8'h00);
    end
    results();
  end

  // A run of 40 rounds takes far less than this span.
  initial begin
    #50us;
    mismatches++;
    results();
  end
endmodule // test_status_byte_service_request

`default_nettype wire
